/* File: design/hsd_pkg.sv */
// shared constants and types for the hub status display and config glue
// assumes a single 200 MHz clock and active-low controller status bits
package hsd_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned BUF_DELAY_NS  = 100;   // reset-to-buffer skew
  localparam int unsigned RST_HOLD_NS   = 1000;  // controller reset width
  localparam int unsigned STRETCH_MS    = 100;   // visible overlong time
  localparam int unsigned DEBOUNCE_US   = 2000;  // button settle time
  localparam int unsigned BUF_DELAY_CYC =
    (BUF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_HOLD_CYC  =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRETCH_CYC   = STRETCH_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned LD_CNT_W      = 16;
  localparam int unsigned STRETCH_W     = 25;
  localparam int unsigned DEBOUNCE_W    = 20;

  // ****************************************
  // strobed status layout
  // ****************************************
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ST_W         = 4;
  localparam int unsigned ST_OVERLONG  = 0;
  localparam int unsigned ST_COLLISION = 1;
  localparam int unsigned ST_RECEIVE   = 2;
  localparam int unsigned ST_PARTITION = 3;
  localparam int unsigned ADDR_LSB     = 5;
  localparam int unsigned ADDR_W       = 3;
  localparam int unsigned PORT_W       = 5;
  localparam int unsigned PORTS        = 8;

  // ****************************************
  // configuration word
  // ****************************************
  localparam int unsigned CFG_W       = 8;
  localparam int unsigned CFG_CC_BIT  = 0;
  localparam int unsigned CFG_TX_BIT  = 1;
  localparam int unsigned CFG_POL_BIT = 2;
  localparam int unsigned CFG_MAX_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_FIXED = 8'h00;

  // load sequencer, gray along the path
  typedef enum logic [1:0]
  {
    LD_IDLE    = 2'b00,
    LD_HOLD    = 2'b01,
    LD_DRIVE   = 2'b11,
    LD_RELEASE = 2'b10
  } hsd_load_e;

  // the four lines that pass the bidirectional transceiver
  typedef struct packed
  {
    logic cascade_rx_enable;
    logic cascade_rx_clock;
    logic cascade_collision_n;
    logic cascade_rx_data;
  } hsd_casc_s;

  // the four board indicators, active high
  typedef struct packed
  {
    logic any_partition_indicator;
    logic receive_indicator;
    logic collision_indicator;
    logic overlong_packet_indicator;
  } hsd_ind_s;

endpackage

/* File: design/hsd_status_latch.sv */
// one controller's status capture: summary nibble or per-port array
// assumes strobe and data are synchronous to ref_clk
module hsd_status_latch #(
  parameter int unsigned PORTS  = hsd_pkg::PORTS,
  parameter int unsigned PORT_W = hsd_pkg::PORT_W
)(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  // controller side
  input  wire logic                   status_strobe,
  input  wire logic [hsd_pkg::DATA_W-1:0] data,
  input  wire logic                   max_mode,
  // captured status
  output logic [hsd_pkg::ST_W-1:0]    min_status,
  output logic [PORTS-1:0][PORT_W-1:0] port_status
);

  logic                         strobe_q;
  logic                         next_strobe_q;
  logic [hsd_pkg::ST_W-1:0]     next_min_status;
  logic [PORTS-1:0][PORT_W-1:0] next_port_status;
  logic                         rise;
  logic [hsd_pkg::ADDR_W-1:0]   addr;

  // ****************************************
  // capture on the strobe's rising edge
  // ****************************************
  assign rise = status_strobe & ~strobe_q;
  assign addr = data[hsd_pkg::ADDR_LSB +: hsd_pkg::ADDR_W];

  // summary nibble in min mode, addressed write in max mode
  always_comb
  begin
    next_strobe_q    = status_strobe;
    next_min_status  = min_status;
    next_port_status = port_status;
    if (rise)
    begin
      if (max_mode)
        next_port_status[addr] = data[PORT_W-1:0];
      else
        next_min_status = data[hsd_pkg::ST_W-1:0];
    end
  end

  // all ones after reset: every condition reads inactive
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strobe_q    <= 1'b0;
      min_status  <= '1;
      port_status <= '1;
    end
    else if (clk_en)
    begin
      strobe_q    <= next_strobe_q;
      min_status  <= next_min_status;
      port_status <= next_port_status;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  capture_min_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rise && !max_mode) |=> min_status == $past(data[3:0]))
    else $error("summary status not captured on strobe");

  hold_min_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !rise) |=> $stable(min_status))
    else $error("summary status changed without strobe");

  port_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rise && max_mode) |=>
      port_status[$past(addr)] == $past(data[PORT_W-1:0]))
    else $error("addressed port status not written");

endmodule

/* File: design/hsd_stretch.sv */
// pulse stretcher for the short overlong-packet condition
// assumes the input is a registered level in the ref_clk domain
module hsd_stretch #(
  parameter int unsigned CYC = hsd_pkg::STRETCH_CYC,
  parameter int unsigned CW  = hsd_pkg::STRETCH_W
)(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // level in and stretched level out
  input  wire logic level_in,
  output logic      level_out
);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_level_out;

  // reload while active, then count down; output holds until zero
  always_comb
  begin
    next_cnt       = cnt;
    next_level_out = level_in || (cnt != '0);
    if (level_in)
      next_cnt = CW'(CYC);
    else if (cnt != '0)
      next_cnt = cnt - 1'b1;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt       <= '0;
      level_out <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt       <= next_cnt;
      level_out <= next_level_out;
    end
  end

  stretch_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && level_in) |=> (level_out && cnt == CW'(CYC)))
    else $error("stretcher did not reload");

  stretch_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !level_in && cnt == '0) |=> !level_out)
    else $error("stretcher stayed on after interval");

endmodule

/* File: design/hsd_top.sv */
// board glue: status display, cascade bus drivers, configuration load
// assumes all pins are synchronous to ref_clk; open-collector and
// transceiver wire levels are resolved outside from the enables
module hsd_top #(
  parameter int unsigned STRETCH_CYC  = hsd_pkg::STRETCH_CYC,
  parameter int unsigned DEBOUNCE_CYC = hsd_pkg::DEBOUNCE_CYC
)(
  // clock, reset, enable
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  // controller a status bus
  input  wire logic                        status_strobe_a,
  input  wire logic [hsd_pkg::DATA_W-1:0]  data_a,
  // controller b status bus
  input  wire logic                        status_strobe_b,
  input  wire logic [hsd_pkg::DATA_W-1:0]  data_b,
  // user controls
  input  wire logic                        display_mode_sel,
  input  wire logic                        sw_cc,
  input  wire logic                        sw_tx,
  input  wire logic                        sw_pol,
  input  wire logic                        reset_button_n,
  // cascade connector sense and pull-ups
  input  wire logic                        cascade_in_connected,
  output logic                             pullup_oe,
  // open-collector activity lines
  input  wire logic                        ctrl_activity_n,
  input  wire logic                        ctrl_any_transmit_n,
  input  wire logic                        cascade_activity_n_i,
  output logic                             cascade_activity_n_o,
  output logic                             cascade_activity_n_oe,
  input  wire logic                        cascade_any_transmit_n_i,
  output logic                             cascade_any_transmit_n_o,
  output logic                             cascade_any_transmit_n_oe,
  output logic                             ctrl_activity_in_n,
  output logic                             ctrl_any_transmit_in_n,
  // transceiver lines
  input  wire hsd_pkg::hsd_casc_s          ctrl_casc_out,
  input  wire logic                        ctrl_casc_drive,
  input  wire hsd_pkg::hsd_casc_s          cascade_i,
  output hsd_pkg::hsd_casc_s               cascade_o,
  output logic                             cascade_oe,
  output hsd_pkg::hsd_casc_s               ctrl_casc_in,
  // configuration to both controllers
  output logic                             ctrl_reset_n,
  output logic                             config_oe,
  output logic [hsd_pkg::CFG_W-1:0]        config_word_a,
  output logic [hsd_pkg::CFG_W-1:0]        config_word_b,
  // indicators
  output hsd_pkg::hsd_ind_s                ind,
  output logic [hsd_pkg::PORTS-1:0][hsd_pkg::PORT_W-1:0] port_status_a,
  output logic [hsd_pkg::PORTS-1:0][hsd_pkg::PORT_W-1:0] port_status_b
);

  // ****************************************
  // helpers
  // ****************************************
  // active-low OR of two status bits, active-high result
  function automatic logic any_low(input logic a, input logic b);
    any_low = ~(a & b);
  endfunction

  function automatic logic [hsd_pkg::CFG_W-1:0] cfg_build(
    input logic cc, input logic tx, input logic pol, input logic mx);
    logic [hsd_pkg::CFG_W-1:0] w;
    w = hsd_pkg::CFG_FIXED;
    w[hsd_pkg::CFG_CC_BIT]  = cc;
    w[hsd_pkg::CFG_TX_BIT]  = tx;
    w[hsd_pkg::CFG_POL_BIT] = pol;
    w[hsd_pkg::CFG_MAX_BIT] = mx;
    cfg_build = w;
  endfunction

  // ****************************************
  // status capture and display
  // ****************************************
  logic [hsd_pkg::ST_W-1:0] min_a;
  logic [hsd_pkg::ST_W-1:0] min_b;
  logic                     max_mode;
  logic                     next_max_mode;
  logic                     overlong_raw;
  logic                     next_overlong_raw;
  logic                     overlong_str;
  hsd_pkg::hsd_ind_s        next_ind;

  // separate instances keep the two data buses apart
  hsd_status_latch u_latch_a (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .clk_en        (clk_en),
    .status_strobe (status_strobe_a),
    .data          (data_a),
    .max_mode      (max_mode),
    .min_status    (min_a),
    .port_status   (port_status_a)
  );

  hsd_status_latch u_latch_b (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .clk_en        (clk_en),
    .status_strobe (status_strobe_b),
    .data          (data_b),
    .max_mode      (max_mode),
    .min_status    (min_b),
    .port_status   (port_status_b)
  );

  hsd_stretch #(
    .CYC (STRETCH_CYC)
  ) u_stretch (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .level_in  (overlong_raw),
    .level_out (overlong_str)
  );

  // combine both controllers; receive and collision need no stretch
  // because the controllers already hold them long enough
  always_comb
  begin
    next_overlong_raw = any_low(min_a[hsd_pkg::ST_OVERLONG],
                                min_b[hsd_pkg::ST_OVERLONG]);
    next_ind.overlong_packet_indicator = overlong_str;
    next_ind.collision_indicator = any_low(min_a[hsd_pkg::ST_COLLISION],
                                   min_b[hsd_pkg::ST_COLLISION]);
    next_ind.receive_indicator = any_low(min_a[hsd_pkg::ST_RECEIVE],
                                 min_b[hsd_pkg::ST_RECEIVE]);
    next_ind.any_partition_indicator =
      any_low(min_a[hsd_pkg::ST_PARTITION],
              min_b[hsd_pkg::ST_PARTITION]);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      overlong_raw <= 1'b0;
      ind          <= '0;
    end
    else if (clk_en)
    begin
      overlong_raw <= next_overlong_raw;
      ind          <= next_ind;
    end
  end

  // ****************************************
  // cascade bus
  // ****************************************
  logic               next_pullup_oe;
  logic               next_act_oe;
  logic               next_anyx_oe;
  logic               next_casc_oe;
  hsd_pkg::hsd_casc_s next_cascade_o;

  // open-collector lines only ever pull low; transceiver follows the
  // controller's direction so the bus has one driver at a time
  always_comb
  begin
    next_pullup_oe = ~cascade_in_connected;
    next_act_oe    = ~ctrl_activity_n;
    next_anyx_oe   = ~ctrl_any_transmit_n;
    next_casc_oe   = ctrl_casc_drive;
    next_cascade_o = ctrl_casc_out;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pullup_oe                 <= 1'b0;
      cascade_activity_n_o      <= 1'b0;
      cascade_activity_n_oe     <= 1'b0;
      cascade_any_transmit_n_o  <= 1'b0;
      cascade_any_transmit_n_oe <= 1'b0;
      ctrl_activity_in_n        <= 1'b1;
      ctrl_any_transmit_in_n    <= 1'b1;
      cascade_o                 <= '0;
      cascade_oe                <= 1'b0;
      ctrl_casc_in              <= '0;
    end
    else if (clk_en)
    begin
      pullup_oe                 <= next_pullup_oe;
      cascade_activity_n_o      <= 1'b0;
      cascade_activity_n_oe     <= next_act_oe;
      cascade_any_transmit_n_o  <= 1'b0;
      cascade_any_transmit_n_oe <= next_anyx_oe;
      ctrl_activity_in_n        <= cascade_activity_n_i;
      ctrl_any_transmit_in_n    <= cascade_any_transmit_n_i;
      cascade_o                 <= next_cascade_o;
      cascade_oe                <= next_casc_oe;
      ctrl_casc_in              <= cascade_i;
    end
  end

  // ****************************************
  // button filter and load sequencer
  // ****************************************
  logic [hsd_pkg::DEBOUNCE_W-1:0] btn_cnt;
  logic [hsd_pkg::DEBOUNCE_W-1:0] next_btn_cnt;
  logic                           press;
  hsd_pkg::hsd_load_e             state;
  hsd_pkg::hsd_load_e             next_state;
  logic [hsd_pkg::LD_CNT_W-1:0]   ld_cnt;
  logic [hsd_pkg::LD_CNT_W-1:0]   next_ld_cnt;
  logic                           next_ctrl_reset_n;
  logic                           next_config_oe;
  logic [hsd_pkg::CFG_W-1:0]      next_config_word;

  // a slow or bouncing button counts as one press once it has been
  // low for the whole filter time; release re-arms it
  always_comb
  begin
    press        = 1'b0;
    next_btn_cnt = btn_cnt;
    if (reset_button_n)
      next_btn_cnt = '0;
    else if (btn_cnt != hsd_pkg::DEBOUNCE_W'(DEBOUNCE_CYC))
    begin
      next_btn_cnt = btn_cnt + 1'b1;
      press = (btn_cnt == hsd_pkg::DEBOUNCE_W'(DEBOUNCE_CYC - 1));
    end
  end

  // hold: reset low, buffers off; drive: buffers on; release: reset
  // high while buffers still drive, so the word is seen at the edge
  always_comb
  begin
    next_state  = state;
    next_ld_cnt = ld_cnt + 1'b1;
    unique case (state)
      hsd_pkg::LD_IDLE:
        next_ld_cnt = '0;
      hsd_pkg::LD_HOLD:
        if (ld_cnt == hsd_pkg::LD_CNT_W'(hsd_pkg::BUF_DELAY_CYC))
        begin
          next_state  = hsd_pkg::LD_DRIVE;
          next_ld_cnt = '0;
        end
      hsd_pkg::LD_DRIVE:
        if (ld_cnt == hsd_pkg::LD_CNT_W'(hsd_pkg::RST_HOLD_CYC))
        begin
          next_state  = hsd_pkg::LD_RELEASE;
          next_ld_cnt = '0;
        end
      hsd_pkg::LD_RELEASE:
        if (ld_cnt == hsd_pkg::LD_CNT_W'(hsd_pkg::BUF_DELAY_CYC))
        begin
          next_state  = hsd_pkg::LD_IDLE;
          next_ld_cnt = '0;
        end
    endcase
    if (press)
    begin
      next_state  = hsd_pkg::LD_HOLD;
      next_ld_cnt = '0;
    end
    next_ctrl_reset_n = (next_state == hsd_pkg::LD_IDLE) ||
                        (next_state == hsd_pkg::LD_RELEASE);
    next_config_oe    = (next_state == hsd_pkg::LD_DRIVE) ||
                        (next_state == hsd_pkg::LD_RELEASE);
    // switches sampled only on entry to drive, ignored otherwise
    next_config_word  = config_word_a;
    next_max_mode     = max_mode;
    if (next_state == hsd_pkg::LD_DRIVE && state != hsd_pkg::LD_DRIVE)
    begin
      next_config_word = cfg_build(sw_cc, sw_tx, sw_pol,
                                   display_mode_sel);
      next_max_mode    = display_mode_sel;
    end
  end

  // power-on starts a load straight away
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      btn_cnt       <= '0;
      state         <= hsd_pkg::LD_HOLD;
      ld_cnt        <= '0;
      ctrl_reset_n  <= 1'b0;
      config_oe     <= 1'b0;
      config_word_a <= hsd_pkg::CFG_FIXED;
      config_word_b <= hsd_pkg::CFG_FIXED;
      max_mode      <= 1'b0;
    end
    else if (clk_en)
    begin
      btn_cnt       <= next_btn_cnt;
      state         <= next_state;
      ld_cnt        <= next_ld_cnt;
      ctrl_reset_n  <= next_ctrl_reset_n;
      config_oe     <= next_config_oe;
      config_word_a <= next_config_word;
      config_word_b <= next_config_word;
      max_mode      <= next_max_mode;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence rst_rise_s;
    $rose(ctrl_reset_n);
  endsequence

  sequence buf_rise_s;
    $rose(config_oe);
  endsequence

  pullup_top_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && cascade_in_connected) |=> !pullup_oe)
    else $error("pull-ups on with cascade input connected");

  open_coll_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en |=> !cascade_activity_n_o && !cascade_any_transmit_n_o &&
      cascade_activity_n_oe == !$past(ctrl_activity_n) &&
      cascade_any_transmit_n_oe == !$past(ctrl_any_transmit_n))
    else $error("open-collector line not following controller");

  combine_or_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en |=> ind.collision_indicator ==
      $past(!(min_a[1] && min_b[1])))
    else $error("collision indicator not the OR of both");

  any_part_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && (!min_a[3] || !min_b[3])) |=> ind.any_partition_indicator)
    else $error("partition indicator off while partitioned");

  same_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    config_word_a == config_word_b)
    else $error("controllers given different configuration");

  buf_lag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rst_rise_s |-> config_oe[*8])
    else $error("buffers released with controller reset");

  buf_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    buf_rise_s |-> !ctrl_reset_n)
    else $error("buffers enabled outside controller reset");

  cfg_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == hsd_pkg::LD_IDLE && $past(state == hsd_pkg::LD_IDLE))
      |-> $stable(config_word_a) && $stable(max_mode))
    else $error("configuration changed outside a load");

  press_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && press) |=> state == hsd_pkg::LD_HOLD && !ctrl_reset_n)
    else $error("button press did not start a load");

  max_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(config_oe) |-> config_word_a[3] == max_mode)
    else $error("display mode not loaded into configuration");

endmodule

/* File: sim/hsd_ctrl_model.sv */
// behavioural repeater controller that strobes status bytes on its bus
// assumes send is called just after a rising edge of ref_clk
module hsd_ctrl_model
(
  // bench clock
  input  wire logic                       ref_clk,
  // strobed status bus
  output logic                            strobe,
  output logic [hsd_pkg::DATA_W-1:0]      data
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus: nothing asserted, all status bits inactive high
  initial
  begin
    strobe = 1'b0;
    data   = 8'hFF;
  end
  // one byte, stable across the capture edge
  task automatic send(input logic [7:0] b);
    data   = b;
    strobe = 1'b1;
    @(posedge ref_clk);
    #1 strobe = 1'b0;
    @(posedge ref_clk);
    // hold has run out, so the bus stops showing the old byte
    #1 data = ~b;
  endtask
endmodule

/* File: sim/test_hsd_top.sv */
// self-checking bench for the hub status display and config glue
// assumes two controller models on the strobed status buses
module test_hsd_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, sys_rst, clk_en, display_mode_sel, sw_cc, sw_tx, sw_pol;
  logic reset_button_n, cascade_in_connected, pullup_oe;
  logic ctrl_activity_n, ctrl_any_transmit_n, ctrl_casc_drive, cascade_oe;
  logic cascade_activity_n_i, cascade_activity_n_o, cascade_activity_n_oe;
  logic cascade_any_transmit_n_i, cascade_any_transmit_n_o;
  logic cascade_any_transmit_n_oe, ctrl_activity_in_n;
  logic ctrl_any_transmit_in_n, ctrl_reset_n, config_oe;
  logic status_strobe_a, status_strobe_b;
  logic [7:0] data_a, data_b, config_word_a, config_word_b;
  hsd_pkg::hsd_casc_s ctrl_casc_out, cascade_i, cascade_o, ctrl_casc_in;
  hsd_pkg::hsd_ind_s ind;
  logic [7:0][4:0] port_status_a, port_status_b;
  int bad_count, compares;
  // open-collector and transceiver wires, pulled up when undriven
  assign cascade_activity_n_i = ~cascade_activity_n_oe;
  assign cascade_any_transmit_n_i = ~cascade_any_transmit_n_oe;
  assign cascade_i = cascade_oe ? cascade_o : 4'hF;
  hsd_ctrl_model ctl_a (.ref_clk, .strobe(status_strobe_a), .data(data_a));
  hsd_ctrl_model ctl_b (.ref_clk, .strobe(status_strobe_b), .data(data_b));
  hsd_top #(.STRETCH_CYC(10), .DEBOUNCE_CYC(4)) DUT (.ref_clk, .sys_rst,
    .clk_en, .status_strobe_a, .data_a, .status_strobe_b, .data_b,
    .display_mode_sel, .sw_cc, .sw_tx, .sw_pol, .reset_button_n,
    .cascade_in_connected, .pullup_oe, .ctrl_activity_n,
    .ctrl_any_transmit_n, .cascade_activity_n_i, .cascade_activity_n_o,
    .cascade_activity_n_oe, .cascade_any_transmit_n_i,
    .cascade_any_transmit_n_o, .cascade_any_transmit_n_oe,
    .ctrl_activity_in_n, .ctrl_any_transmit_in_n, .ctrl_casc_out,
    .ctrl_casc_drive, .cascade_i, .cascade_o, .cascade_oe, .ctrl_casc_in,
    .ctrl_reset_n, .config_oe, .config_word_a, .config_word_b, .ind,
    .port_status_a, .port_status_b);
  // 200 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // bounded wait on the config buffer enable
  task automatic wait_cfg(input logic lvl);
    int n;
    n = 0;
    while (config_oe !== lvl && n < 400)
    begin
      step(1);
      n++;
    end
    if (n == 400)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  initial
  begin
    {sys_rst, clk_en, reset_button_n, sw_cc, sw_pol} = 5'h1F;
    {display_mode_sel, sw_tx, cascade_in_connected} = 3'h0;
    {ctrl_activity_n, ctrl_any_transmit_n, ctrl_casc_drive} = 3'h6;
    ctrl_casc_out = 4'h0;
    step(2);
    check(ctrl_reset_n, 1'b0);
    sys_rst = 1'b0;
    step(1);
    check(pullup_oe, 1'b1);
    wait_cfg(1'b1);
    check(config_word_a, 8'h05);
    check(config_word_b, 8'h05);
    sw_tx = 1'b1;
    wait_cfg(1'b0);
    check(ctrl_reset_n, 1'b1);
    check(config_word_a, 8'h05);
    cascade_in_connected = 1'b1;
    {ctrl_activity_n, ctrl_any_transmit_n} = 2'b00;
    ctrl_casc_out = 4'h9;
    ctrl_casc_drive = 1'b1;
    step(2);
    check(pullup_oe, 1'b0);
    check({cascade_activity_n_oe, ctrl_activity_in_n}, 2'b10);
    check({cascade_oe, cascade_o, ctrl_casc_in}, 9'h199);
    check({cascade_any_transmit_n_oe, ctrl_any_transmit_in_n}, 2'b10);
    check({cascade_any_transmit_n_o, cascade_activity_n_o}, 2'b00);
    ctl_a.send(8'hFD);
    step(1);
    check(ind, 4'h2);
    ctl_b.send(8'hF7);
    step(1);
    check(ind, 4'hA);
    ctl_a.send(8'hFF);
    step(1);
    check(ind, 4'h8);
    clk_en = 1'b0;
    ctl_b.send(8'hF3);
    step(1);
    check(ind, 4'h8);
    clk_en = 1'b1;
    ctl_b.send(8'hF3);
    step(1);
    check(ind, 4'hC);
    ctl_a.send(8'hFE);
    step(2);
    check(ind.overlong_packet_indicator, 1'b1);
    ctl_a.send(8'hFF);
    step(8);
    check(ind.overlong_packet_indicator, 1'b1);
    step(6);
    check(ind.overlong_packet_indicator, 1'b0);
    display_mode_sel = 1'b1;
    {sw_cc, sw_pol} = 2'b00;
    reset_button_n = 1'b0;
    step(6);
    reset_button_n = 1'b1;
    wait_cfg(1'b1);
    check(config_word_a, 8'h0A);
    wait_cfg(1'b0);
    ctl_a.send(8'hAA);
    step(1);
    check(port_status_a[5], 5'h0A);
    ctl_b.send(8'h3B);
    step(1);
    check(port_status_b[1], 5'h1B);
    sys_rst = 1'b1;
    step(1);
    check({ctrl_reset_n, config_oe, ind}, 6'h00);
    sys_rst = 1'b0;
    step(2);
    check(ctrl_reset_n, 1'b0);
    tally_and_finish();
  end
endmodule
